// ===== pmdb_defs.vh
// Purpose: Constants for the peripheral disable register bank.
// Assumes: Included by its bare name; definitions only.
// Notes:   Register indices are the printed offsets; byte address is four times the index.
`ifndef PMDB_DEFS_VH
`define PMDB_DEFS_VH

// ********************************
// Register indices and geometry
// ********************************
`define PMDB_IDX_CTRL0 12'hee1
`define PMDB_IDX_CTRL1 12'hee2
`define PMDB_IDX_CTRL2 12'hee3
`define PMDB_IDX_CTRL3 12'hee4
`define PMDB_IDX_CTRL4 12'hee5
`define PMDB_IDX_CTRL5 12'hee6
`define PMDB_NUM_REGS 6
`define PMDB_SLOT_MISS 3'h7
`define PMDB_RESET_VAL 8'h00
`define PMDB_RD_ZERO 32'h00000000
`define PMDB_RD_PAD 24'h000000

// ********************************
// Implemented bits of each register
// ********************************
`define PMDB_MASK_CTRL0 8'hff
`define PMDB_MASK_CTRL1 8'h7f
`define PMDB_MASK_CTRL2 8'h67
`define PMDB_MASK_CTRL3 8'h0f
`define PMDB_MASK_CTRL4 8'hf1
`define PMDB_MASK_CTRL5 8'h01

// ********************************
// Field positions
// ********************************
`define PMDB_B0_SYSCLK 7
`define PMDB_B0_VREF 6
`define PMDB_B0_VDET 5
`define PMDB_B0_CSUM 4
`define PMDB_B0_SCAN 3
`define PMDB_B0_NVM 2
`define PMDB_B0_REFCLK 1
`define PMDB_B0_PINCHG 0
`define PMDB_B1_TMR_HI 6
`define PMDB_B2_DAC 6
`define PMDB_B2_ADC 5
`define PMDB_B2_CMP2 2
`define PMDB_B2_CMP1 1
`define PMDB_B2_ZC 0
`define PMDB_B3_PWM4 3
`define PMDB_B3_PWM3 2
`define PMDB_B3_CC2 1
`define PMDB_B3_CC1 0
`define PMDB_B4_SER2 7
`define PMDB_B4_SER1 6
`define PMDB_B4_SYN2 5
`define PMDB_B4_SYN1 4
`define PMDB_B4_WAVE 0
`define PMDB_B5_DSM 0

// ********************************
// Timing
// ********************************
`define PMDB_CLK_NS 100
`define PMDB_NVM_WAIT_NS 1000
`define PMDB_DIV_LAST 2'h3

`endif

// ===== pmdb_bank.v
// Purpose: Peripheral disable register bank with per-peripheral off controls.
// Assumes: Avalon-MM slave with waitrequest on clk_sys (10 MHz); byte address in.
// Notes:   Each off output holds its peripheral in reset, blanks its registers
//          and forces its outputs off; all outputs are flip-flops.
//          Straps pass two flops, so they reach the off outputs three edges late.
//          Limitation: the memory settle wait is rounded down to whole clocks.
//
// Implementation choice: the Avalon-MM register port.
`include "pmdb_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module pmdb_bank #(
    parameter ADDR_W = 14
) (
    input wire clk_sys,
    input wire rst,
    input wire [ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire scanner_cfg_enable,
    input wire zero_cross_cfg_on,
    output reg fosc_tick,
    output reg instr_tick,
    output reg nvmem_ready,
    output reg vref_off,
    output reg volt_detect_off,
    output reg checksum_off,
    output reg mem_scanner_off,
    output reg nvmem_off,
    output reg ref_clock_out_off,
    output reg pin_change_irq_off,
    output reg [6:0] timer_n_off,
    output reg dac_off,
    output reg adc_off,
    output reg [1:0] comparator_n_off,
    output reg zero_cross_off,
    output reg pwm_unit4_off,
    output reg pwm_unit3_off,
    output reg capcomp2_off,
    output reg capcomp1_off,
    output reg serial_port2_off,
    output reg serial_port1_off,
    output reg sync_serial2_off,
    output reg sync_serial1_off,
    output reg waveform_gen_off,
    output reg signal_modulator_off
);

    // ********************************
    // Constants
    // ********************************

    // Longest wait rounds down, never below one cycle; the counter is
    // four bits wide, so the cut to four bits below is on purpose
    localparam integer NVM_WAIT_RAW = (`PMDB_NVM_WAIT_NS / `PMDB_CLK_NS) > 0 ?
        (`PMDB_NVM_WAIT_NS / `PMDB_CLK_NS) : 1;
    localparam [3:0] NVM_WAIT_CYC = NVM_WAIT_RAW[3:0];

    // ********************************
    // Functions
    // ********************************

    // Index to storage slot; miss code for unmapped addresses
    function [2:0] pmdb_slot;
        input [ADDR_W-3:0] idx;
        begin
            case (idx)
                `PMDB_IDX_CTRL0: pmdb_slot = 3'h0;
                `PMDB_IDX_CTRL1: pmdb_slot = 3'h1;
                `PMDB_IDX_CTRL2: pmdb_slot = 3'h2;
                `PMDB_IDX_CTRL3: pmdb_slot = 3'h3;
                `PMDB_IDX_CTRL4: pmdb_slot = 3'h4;
                `PMDB_IDX_CTRL5: pmdb_slot = 3'h5;
                default: pmdb_slot = `PMDB_SLOT_MISS;
            endcase
        end
    endfunction

    // Implemented bits of a slot
    function [7:0] pmdb_mask;
        input [2:0] slot;
        begin
            case (slot)
                3'h0: pmdb_mask = `PMDB_MASK_CTRL0;
                3'h1: pmdb_mask = `PMDB_MASK_CTRL1;
                3'h2: pmdb_mask = `PMDB_MASK_CTRL2;
                3'h3: pmdb_mask = `PMDB_MASK_CTRL3;
                3'h4: pmdb_mask = `PMDB_MASK_CTRL4;
                3'h5: pmdb_mask = `PMDB_MASK_CTRL5;
                default: pmdb_mask = 8'h00;
            endcase
        end
    endfunction

    // ********************************
    // Declarations
    // ********************************
    // Six control registers, one per bus word
    reg [7:0] bank_reg [0:`PMDB_NUM_REGS-1];
    // Strap synchronisers
    reg scan_meta_reg;
    reg scan_sync_reg;
    reg zc_meta_reg;
    reg zc_sync_reg;
    // Clock divider and memory settle counter
    reg [1:0] div_reg;
    reg [3:0] nvm_cnt_reg;
    // Bus decode results
    wire bus_req;
    wire [2:0] bus_slot;
    wire bus_hit;
    wire do_write;
    // Named views of the stored registers
    wire [7:0] ctrl0;
    wire [7:0] ctrl1;
    wire [7:0] ctrl2;
    wire [7:0] ctrl3;
    wire [7:0] ctrl4;
    wire [7:0] ctrl5;
    integer i;

    // ********************************
    // Bus decode
    // ********************************

    // Only word-aligned index matters; low two address bits are ignored
    // Unmapped indices give the miss code, so their reads return zero
    assign bus_req = avs_read | avs_write;
    assign bus_slot = pmdb_slot(avs_address[ADDR_W-1:2]);
    assign bus_hit = (bus_slot != `PMDB_SLOT_MISS);
    // Write lands at the edge where the master sees waitrequest low
    // A write with the low lane disabled is answered but stores nothing
    assign do_write = avs_write & ~avs_waitrequest & bus_hit & avs_byteenable[0];

    assign ctrl0 = bank_reg[0];
    assign ctrl1 = bank_reg[1];
    assign ctrl2 = bank_reg[2];
    assign ctrl3 = bank_reg[3];
    assign ctrl4 = bank_reg[4];
    assign ctrl5 = bank_reg[5];

    // ********************************
    // Bus handshake
    // ********************************

    // One wait cycle per access; readdata is loaded as waitrequest drops
    // Registered waitrequest costs a cycle but keeps the answer free of
    // any combinational path from the request lines
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= `PMDB_RD_ZERO;
        end else if (bus_req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            if (avs_read && bus_hit) begin
                avs_readdata <= {`PMDB_RD_PAD, bank_reg[bus_slot]};
            end else begin
                avs_readdata <= `PMDB_RD_ZERO;
            end
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // ********************************
    // Register storage
    // ********************************

    // Reset clears every bit so all peripherals come up enabled
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (i = 0; i < `PMDB_NUM_REGS; i = i + 1) begin
                bank_reg[i] <= `PMDB_RESET_VAL;
            end
        end else if (do_write) begin
            // Masking keeps unimplemented bits at zero, so software
            // may write all ones without touching absent positions
            bank_reg[bus_slot] <= avs_writedata[7:0] & pmdb_mask(bus_slot);
        end
    end

    // ********************************
    // Configuration word inputs
    // ********************************

    // Straps come from outside this domain, so two flops first
    // Only the second flop is read; the first may settle late
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            scan_meta_reg <= 1'b0;
            scan_sync_reg <= 1'b0;
            zc_meta_reg <= 1'b0;
            zc_sync_reg <= 1'b0;
        end else begin
            scan_meta_reg <= scanner_cfg_enable;
            scan_sync_reg <= scan_meta_reg;
            zc_meta_reg <= zero_cross_cfg_on;
            zc_sync_reg <= zc_meta_reg;
        end
    end

    // ********************************
    // Peripheral clock enables
    // ********************************

    // Quarter-rate tick runs free; gating touches only the full-rate enable
    // Peripherals on the quarter-rate clock thus keep running while the
    // full-rate network is stopped
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_reg <= 2'h0;
            instr_tick <= 1'b0;
            fosc_tick <= 1'b0;
        end else begin
            div_reg <= div_reg + 2'h1;
            instr_tick <= (div_reg == `PMDB_DIV_LAST);
            fosc_tick <= ~ctrl0[`PMDB_B0_SYSCLK];
        end
    end

    // ********************************
    // Memory module ready
    // ********************************

    // Ready rises a fixed wait after the memory module is re-enabled,
    // so software may poll it instead of timing the delay itself
    // Setting the disable bit again restarts the wait from zero; the
    // count saturates, so ready then stands until the next disable
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            nvm_cnt_reg <= 4'h0;
            nvmem_ready <= 1'b0;
        end else if (ctrl0[`PMDB_B0_NVM]) begin
            nvm_cnt_reg <= 4'h0;
            nvmem_ready <= 1'b0;
        end else begin
            if (nvm_cnt_reg != NVM_WAIT_CYC) begin
                nvm_cnt_reg <= nvm_cnt_reg + 4'h1;
            end
            nvmem_ready <= (nvm_cnt_reg == NVM_WAIT_CYC);
        end
    end

    // ********************************
    // Per-peripheral disable controls
    // ********************************

    // Each off level holds the peripheral in reset, blanks its registers
    // and forces its outputs off; releasing it restores power-on values.
    // Registered so a glitch on the bank never reaches a peripheral reset.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            // Control 0 group comes up enabled, matching the cleared bank
            vref_off <= 1'b0;
            volt_detect_off <= 1'b0;
            checksum_off <= 1'b0;
            mem_scanner_off <= 1'b0;
            nvmem_off <= 1'b0;
            ref_clock_out_off <= 1'b0;
            pin_change_irq_off <= 1'b0;

            // Control 1 group: all timers enabled
            timer_n_off <= 7'h00;

            // Control 2 group: converters, comparators, detector enabled
            dac_off <= 1'b0;
            adc_off <= 1'b0;
            comparator_n_off <= 2'h0;
            zero_cross_off <= 1'b0;

            // Control 3 group: modulators and capture units enabled
            pwm_unit4_off <= 1'b0;
            pwm_unit3_off <= 1'b0;
            capcomp2_off <= 1'b0;
            capcomp1_off <= 1'b0;

            // Control 4 group: serial ports and waveform generator enabled
            serial_port2_off <= 1'b0;
            serial_port1_off <= 1'b0;
            sync_serial2_off <= 1'b0;
            sync_serial1_off <= 1'b0;
            waveform_gen_off <= 1'b0;

            // Control 5 group: data signal modulator enabled
            signal_modulator_off <= 1'b0;
        end else begin
            // Control 0: core helpers, memory and pin-change logic
            vref_off <= ctrl0[`PMDB_B0_VREF];
            volt_detect_off <= ctrl0[`PMDB_B0_VDET];
            checksum_off <= ctrl0[`PMDB_B0_CSUM];
            // A scanner not enabled by configuration is always off
            mem_scanner_off <= ctrl0[`PMDB_B0_SCAN] | ~scan_sync_reg;
            // Blocks memory access and memory-control writes
            nvmem_off <= ctrl0[`PMDB_B0_NVM];
            ref_clock_out_off <= ctrl0[`PMDB_B0_REFCLK];
            pin_change_irq_off <= ctrl0[`PMDB_B0_PINCHG];

            // Control 1: one bit per timer, timer n on bit n
            timer_n_off <= ctrl1[`PMDB_B1_TMR_HI:0];

            // Control 2: converters, comparators and zero-cross detector
            dac_off <= ctrl2[`PMDB_B2_DAC];
            adc_off <= ctrl2[`PMDB_B2_ADC];
            comparator_n_off <= {ctrl2[`PMDB_B2_CMP2], ctrl2[`PMDB_B2_CMP1]};
            // A detector forced on by configuration ignores the bit
            zero_cross_off <= ctrl2[`PMDB_B2_ZC] & ~zc_sync_reg;

            // Control 3: modulators and capture units
            pwm_unit4_off <= ctrl3[`PMDB_B3_PWM4];
            pwm_unit3_off <= ctrl3[`PMDB_B3_PWM3];
            capcomp2_off <= ctrl3[`PMDB_B3_CC2];
            capcomp1_off <= ctrl3[`PMDB_B3_CC1];

            // Control 4: serial ports and waveform generator
            serial_port2_off <= ctrl4[`PMDB_B4_SER2];
            serial_port1_off <= ctrl4[`PMDB_B4_SER1];
            sync_serial2_off <= ctrl4[`PMDB_B4_SYN2];
            sync_serial1_off <= ctrl4[`PMDB_B4_SYN1];
            waveform_gen_off <= ctrl4[`PMDB_B4_WAVE];

            // Control 5: only the data signal modulator exists
            signal_modulator_off <= ctrl5[`PMDB_B5_DSM];
        end
    end

endmodule

`default_nettype wire

// ===== pmdb_bank_monitor.sv
// Purpose: Port checker for the peripheral disable bank.
// Assumes: One clock domain; straps held steady around register writes.
// Notes:   Bound to every bank instance; watches bus inputs, straps and design-driven outputs.
`timescale 1ns/1ps
`default_nettype none
`include "pmdb_defs.vh"
module pmdb_bank_monitor #(
    parameter ADDR_W = 14
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic scanner_cfg_enable,
    input wire logic zero_cross_cfg_on,
    input wire logic fosc_tick,
    input wire logic instr_tick,
    input wire logic nvmem_ready,
    input wire logic mem_scanner_off,
    input wire logic nvmem_off,
    input wire logic [6:0] timer_n_off,
    input wire logic zero_cross_off,
    input wire logic signal_modulator_off
);
    // ****************************************
    // Accepted writes and properties
    // ****************************************
    // A write lands only at its answer edge with the low lane enabled
    wire hit = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire [ADDR_W-3:0] idx = avs_address[ADDR_W-1:2];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_sysclk;
        hit && idx == `PMDB_IDX_CTRL0 |-> ##2 fosc_tick == !$past(avs_writedata[7], 2);
    endproperty
    a_sysclk: assert property (p_sysclk) else $error("clock network gate wrong");
    // Tick is never gated, so it must keep its period of four
    property p_tick;
        instr_tick |=> !instr_tick [*3] ##1 instr_tick;
    endproperty
    a_tick: assert property (p_tick) else $error("instruction tick period wrong");
    property p_scan;
        hit && idx == `PMDB_IDX_CTRL0 |-> ##2
            mem_scanner_off == ($past(avs_writedata[3], 2) | !scanner_cfg_enable);
    endproperty
    a_scan: assert property (p_scan) else $error("scanner off wrong");
    property p_nvm;
        hit && idx == `PMDB_IDX_CTRL0 |-> ##2 nvmem_off == $past(avs_writedata[2], 2);
    endproperty
    a_nvm: assert property (p_nvm) else $error("memory off wrong");
    // Memory must stay unusable for the settling wait after re-enable
    property p_nvm_wait;
        $rose(nvmem_ready) |-> !nvmem_off && !$past(nvmem_off, 10);
    endproperty
    a_nvm_wait: assert property (p_nvm_wait) else $error("memory ready too early");
    property p_timers;
        hit && idx == `PMDB_IDX_CTRL1 |-> ##2 timer_n_off == $past(avs_writedata[6:0], 2);
    endproperty
    a_timers: assert property (p_timers) else $error("timer off wrong");
    property p_zc;
        hit && idx == `PMDB_IDX_CTRL2 |-> ##2
            zero_cross_off == ($past(avs_writedata[0], 2) & !zero_cross_cfg_on);
    endproperty
    a_zc: assert property (p_zc) else $error("zero cross off wrong");
    property p_dsm;
        hit && idx == `PMDB_IDX_CTRL5 |-> ##2
            signal_modulator_off == $past(avs_writedata[0], 2);
    endproperty
    a_dsm: assert property (p_dsm) else $error("modulator off wrong");
    property p_pad;
        !avs_waitrequest |-> avs_readdata[31:8] == `PMDB_RD_PAD &&
            (idx != `PMDB_IDX_CTRL2 || (avs_readdata[7:0] & ~`PMDB_MASK_CTRL2) == 8'h00);
    endproperty
    a_pad: assert property (p_pad) else $error("read data upper lanes not zero");
    c_wr0: cover property (hit && idx == `PMDB_IDX_CTRL0);
    c_wr5: cover property (hit && idx == `PMDB_IDX_CTRL5);
    c_ready: cover property ($rose(nvmem_ready));
endmodule
bind pmdb_bank pmdb_bank_monitor #(.ADDR_W(ADDR_W)) mon_u (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .scanner_cfg_enable(scanner_cfg_enable), .zero_cross_cfg_on(zero_cross_cfg_on),
    .fosc_tick(fosc_tick), .instr_tick(instr_tick), .nvmem_ready(nvmem_ready),
    .mem_scanner_off(mem_scanner_off), .nvmem_off(nvmem_off), .timer_n_off(timer_n_off),
    .zero_cross_off(zero_cross_off), .signal_modulator_off(signal_modulator_off)
);
`default_nettype wire

// ===== tb_top.sv
// Purpose: Self-checking bench for the peripheral disable bank.
// Assumes: Bank answers one cycle after taking a request.
// Notes:   Straps change only away from register writes.
`timescale 1ns/1ps
`default_nettype none
`include "pmdb_defs.vh"
module tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [13:0] avs_address = 14'h0000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hf;
    logic scanner_cfg_enable = 1'b1;
    logic zero_cross_cfg_on = 1'b0;
    wire [31:0] avs_readdata;
    wire [6:0] timer_n_off;
    wire [1:0] comparator_n_off;
    wire avs_waitrequest, fosc_tick, instr_tick, nvmem_ready, vref_off, volt_detect_off;
    wire checksum_off, mem_scanner_off, nvmem_off, ref_clock_out_off, pin_change_irq_off;
    wire dac_off, adc_off, zero_cross_off, pwm_unit4_off, pwm_unit3_off, capcomp2_off;
    wire capcomp1_off, serial_port2_off, serial_port1_off, sync_serial2_off;
    wire sync_serial1_off, waveform_gen_off, signal_modulator_off;
    int miscompares = 0;
    int n_compared = 0;
    localparam logic [47:0] MASKS = {`PMDB_MASK_CTRL5, `PMDB_MASK_CTRL4, `PMDB_MASK_CTRL3,
        `PMDB_MASK_CTRL2, `PMDB_MASK_CTRL1, `PMDB_MASK_CTRL0};
    // Off outputs laid out like the six registers, lowest register first
    wire [47:0] offs = {7'h00, signal_modulator_off, serial_port2_off, serial_port1_off,
        sync_serial2_off, sync_serial1_off, 3'h0, waveform_gen_off, 4'h0, pwm_unit4_off,
        pwm_unit3_off, capcomp2_off, capcomp1_off, 1'b0, dac_off, adc_off, 2'h0,
        comparator_n_off, zero_cross_off, 1'b0, timer_n_off, ~fosc_tick, vref_off,
        volt_detect_off, checksum_off, mem_scanner_off, nvmem_off, ref_clock_out_off,
        pin_change_irq_off};
    pmdb_bank #(.ADDR_W(14)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .scanner_cfg_enable(scanner_cfg_enable),
        .zero_cross_cfg_on(zero_cross_cfg_on), .fosc_tick(fosc_tick),
        .instr_tick(instr_tick), .nvmem_ready(nvmem_ready), .vref_off(vref_off),
        .volt_detect_off(volt_detect_off), .checksum_off(checksum_off),
        .mem_scanner_off(mem_scanner_off), .nvmem_off(nvmem_off),
        .ref_clock_out_off(ref_clock_out_off), .pin_change_irq_off(pin_change_irq_off),
        .timer_n_off(timer_n_off), .dac_off(dac_off), .adc_off(adc_off),
        .comparator_n_off(comparator_n_off), .zero_cross_off(zero_cross_off),
        .pwm_unit4_off(pwm_unit4_off), .pwm_unit3_off(pwm_unit3_off),
        .capcomp2_off(capcomp2_off), .capcomp1_off(capcomp1_off),
        .serial_port2_off(serial_port2_off), .serial_port1_off(serial_port1_off),
        .sync_serial2_off(sync_serial2_off), .sync_serial1_off(sync_serial1_off),
        .waveform_gen_off(waveform_gen_off), .signal_modulator_off(signal_modulator_off)
    );
    // ****************************************
    // Bus tasks and checks
    // ****************************************
    always #50 clk_sys = ~clk_sys;
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {`PMDB_RD_PAD, d};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        // Outputs read here still hold their values from before this edge
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge clk_sys);
            n++;
        end
        if (n == 50)
            miscompares++;
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, idx, d, be, q);
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic rd_chk(input logic [11:0] idx, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, 4'hf, q);
        cmp({16'h0000, q}, {40'h0000000000, exp});
    endtask
    task automatic wait_edges;
        @(posedge clk_sys);
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        end_of_test();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [47:0] cnt;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) rd_chk(`PMDB_IDX_CTRL0 + 12'(i), `PMDB_RESET_VAL);
        rd_chk(12'hee0, 8'h00);
        // Every implemented bit set then cleared, one register at a time
        for (int i = 0; i < 6; i++) begin
            wr(`PMDB_IDX_CTRL0 + 12'(i), 8'hff, 4'hf);
            cmp(offs, {40'h0000000000, MASKS[8*i +: 8]} << (8 * i));
            rd_chk(`PMDB_IDX_CTRL0 + 12'(i), MASKS[8*i +: 8]);
            // No peripheral is touched between the clear and the check
            wr(`PMDB_IDX_CTRL0 + 12'(i), 8'h00, 4'hf);
            cmp(offs, 48'h000000000000);
        end
        wr(`PMDB_IDX_CTRL1, 8'hff, 4'he);
        cmp(offs, 48'h000000000000);
        wr(12'hee7, 8'hff, 4'hf);
        cmp(offs, 48'h000000000000);
        wr(`PMDB_IDX_CTRL0, 8'h80, 4'hf);
        cmp(offs, 48'h000000000080);
        cnt = 48'h000000000000;
        repeat (16) begin
            @(negedge clk_sys);
            cnt = cnt + instr_tick;
        end
        cmp(cnt, 48'h000000000004);
        wr(`PMDB_IDX_CTRL0, 8'h04, 4'hf);
        cmp(nvmem_ready, 1'b0);
        bus(1'b1, `PMDB_IDX_CTRL0, 8'h00, 4'hf, cnt[31:0]);
        // Memory left alone for the whole settling wait after re-enable
        for (int j = 1; j <= 11; j++) begin
            @(posedge clk_sys);
            @(negedge clk_sys);
            if (j >= 10)
                cmp(nvmem_ready, j == 11);
        end
        @(posedge clk_sys);
        scanner_cfg_enable <= 1'b0;
        wait_edges();
        cmp(mem_scanner_off, 1'b1);
        @(posedge clk_sys);
        scanner_cfg_enable <= 1'b1;
        wait_edges();
        cmp(mem_scanner_off, 1'b0);
        wr(`PMDB_IDX_CTRL2, 8'h01, 4'hf);
        @(posedge clk_sys);
        zero_cross_cfg_on <= 1'b1;
        wait_edges();
        cmp(zero_cross_off, 1'b0);
        @(posedge clk_sys);
        zero_cross_cfg_on <= 1'b0;
        wait_edges();
        cmp(zero_cross_off, 1'b1);
        // Reset in mid-run must clear a loaded bank
        wr(`PMDB_IDX_CTRL1, 8'h7f, 4'hf);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        rd_chk(`PMDB_IDX_CTRL1, 8'h00);
        // The scanner strap needs three edges to pass the synchroniser and reach its off output again
        wait_edges();
        cmp(offs, 48'h000000000000);
        end_of_test();
    end
endmodule
`default_nettype wire
